//--- logic/lsr_pkg.sv
// Constants and types for the light sensor command-register block.
package lsr_pkg;
   localparam logic [6:0]  TARGET_ADDR  = 7'h10;
   localparam logic [7:0]  CMD_CONFIG   = 8'h00;
   localparam logic [7:0]  CMD_UPPER    = 8'h01;
   localparam logic [7:0]  CMD_LOWER    = 8'h02;
   localparam logic [7:0]  CMD_PSAVE    = 8'h03;
   localparam logic [7:0]  CMD_LIGHT    = 8'h04;
   localparam logic [7:0]  CMD_BROAD    = 8'h05;
   localparam logic [7:0]  CMD_STATUS   = 8'h06;
   localparam logic [15:0] CONFIG_RESET = 16'h0001;
   localparam logic [15:0] WORD_ZERO    = 16'h0000;
   localparam logic [15:0] PSAVE_MASK   = 16'h0007;
   localparam logic [3:0]  BYTE_BITS    = 4'h8;
   localparam logic [3:0]  LAST_BIT     = 4'h7;
   localparam int GAIN_HI = 12;
   localparam int GAIN_LO = 11;
   localparam int IT_HI   = 9;
   localparam int IT_LO   = 6;
   localparam int PERS_HI = 5;
   localparam int PERS_LO = 4;
   localparam int IRQ_BIT = 1;
   localparam int SD_BIT  = 0;
   localparam int PSEL_HI = 2;
   localparam int PSEL_LO = 1;
   localparam int PSEN_BIT = 0;
   localparam int LOW_FLAG_BIT  = 15;
   localparam int HIGH_FLAG_BIT = 14;
   localparam logic [3:0]  IT_25  = 4'hC;
   localparam logic [3:0]  IT_50  = 4'h8;
   localparam logic [3:0]  IT_200 = 4'h1;
   localparam logic [3:0]  IT_400 = 4'h2;
   localparam logic [3:0]  IT_800 = 4'h3;
   localparam logic [12:0] MS_25  = 13'h0019;
   localparam logic [12:0] MS_50  = 13'h0032;
   localparam logic [12:0] MS_100 = 13'h0064;
   localparam logic [12:0] MS_200 = 13'h00C8;
   localparam logic [12:0] MS_400 = 13'h0190;
   localparam logic [12:0] MS_800 = 13'h0320;
   localparam logic [12:0] PSM_EXTRA_MS = 13'h01F4;
   localparam int CLK_HZ     = 40000000;
   localparam int TICK_MS    = 1;
   localparam int MS_CYCLES  = CLK_HZ / 1000 * TICK_MS;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_RX    = 3'b001,
      ST_ACK   = 3'b010,
      ST_TX    = 3'b011,
      ST_TXACK = 3'b100
   } lsr_state_e;
   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_CMD  = 2'b01,
      PH_LO   = 2'b10,
      PH_HI   = 2'b11
   } lsr_phase_e;
endpackage

//--- logic/lsr_regs.sv
// Light sensor command registers behind a two-wire serial target port.
//
// Operation
// - Answer only target address 0x10; address is fixed.
// - Address byte LSB picks direction: 20h writes, 21h reads.
// - Serial clock from 10 kHz to 400 kHz, supplied by host.
// - Command codes 00h to 06h decoded; every register is 16 bits.
// - Last light result held and readable unchanged during shutdown.
// - After leaving shutdown, new measurements replace the held result.
// - Configuration resets to 01, so the device starts shut down.
// - Configuration bits 12:11 select gain.
// - Configuration bits 9:6 select integration time 25 to 800 ms.
// - Configuration bits 5:4 set persistence of 1, 2, 4 or 8.
// - Configuration bit 1 enables threshold evaluation.
// - Configuration bit 0 set means shutdown, clear means measuring.
// - Register 01h holds the 16-bit upper threshold.
// - Register 02h holds the 16-bit lower threshold.
// - Power-saving bits 2:1 select one of four modes.
// - Power-saving bit 0 enables power-saving operation.
// - Register 04h reads the light result, low byte first.
// - Register 05h reads the broadband result.
// - Register 06h reads the threshold event status.
// - No interrupt pin; host polls the status register.
// - Status bit 15 flags lower crossing, bit 14 upper crossing.
// - Refresh period follows mode and integration time.
`timescale 1ns/100ps
module lsr_regs #(
   parameter int MS_CYCLES = lsr_pkg::MS_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic [15:0] light_sample_i,
   input  wire logic [15:0] broad_sample_i,
   input  wire logic        sample_valid_i,
   output logic             meas_start_o,
   output logic             shutdown_o,
   output logic [1:0]       gain_select_o,
   output logic [3:0]       integration_time_select_o
);
   import lsr_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
   always_ff @(posedge clk_i) begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
   end
   logic scl_rise, scl_fall, start_seen, stop_seen;
   assign scl_rise   = scl_sync & ~scl_prev;
   assign scl_fall   = ~scl_sync & scl_prev;
   assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
   assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;

   // ----------------------------------------
   // Registers and serial target
   // ----------------------------------------
   lsr_state_e  state, next_state;
   lsr_phase_e  phase, next_phase;
   logic [3:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  shreg, next_shreg, cmd, next_cmd, hold, next_hold;
   logic        rw, next_rw, tx_hi, next_tx_hi, nack, next_nack;
   logic        sda_oe, next_sda_oe, status_clr, next_status_clr;
   logic [15:0] measure_config, next_measure_config;
   logic [15:0] upper_limit, next_upper_limit;
   logic [15:0] lower_limit, next_lower_limit;
   logic [15:0] power_save_ctrl, next_power_save_ctrl;
   logic [15:0] light_result, broadband_result, limit_crossing_status, rd_word;
   logic        upper_crossing_flag, lower_crossing_flag;

   // Read-only results; write-only registers read as zero.
   always_comb begin
      if (cmd == CMD_LIGHT) begin
         rd_word = light_result;
      end else if (cmd == CMD_BROAD) begin
         rd_word = broadband_result;
      end else if (cmd == CMD_STATUS) begin
         rd_word = limit_crossing_status;
      end else begin
         rd_word = WORD_ZERO;
      end
   end

   always_comb begin
      next_state = state;
      next_phase = phase;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_cmd = cmd;
      next_hold = hold;
      next_rw = rw;
      next_tx_hi = tx_hi;
      next_nack = nack;
      next_sda_oe = sda_oe;
      next_status_clr = 1'b0;
      next_measure_config = measure_config;
      next_upper_limit = upper_limit;
      next_lower_limit = lower_limit;
      next_power_save_ctrl = power_save_ctrl;
      if (start_seen) begin
         next_state = ST_RX;
         next_phase = PH_ADDR;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
      end else if (stop_seen) begin
         next_state = ST_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         case (state)
            ST_RX: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_sync};
                  next_bit_cnt = bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                  next_state = ST_ACK;
                  next_sda_oe = 1'b1;
                  case (phase)
                     PH_ADDR: begin
                        if (shreg[7:1] == TARGET_ADDR) begin
                           next_rw = shreg[0];
                        end else begin
                           next_state = ST_IDLE;
                           next_sda_oe = 1'b0;
                        end
                     end
                     PH_CMD: next_cmd = shreg;
                     PH_LO: next_hold = shreg;
                     default: begin
                        if (cmd == CMD_CONFIG) begin
                           next_measure_config = {shreg, hold};
                        end else if (cmd == CMD_UPPER) begin
                           next_upper_limit = {shreg, hold};
                        end else if (cmd == CMD_LOWER) begin
                           next_lower_limit = {shreg, hold};
                        end else if (cmd == CMD_PSAVE) begin
                           next_power_save_ctrl = {shreg, hold} & PSAVE_MASK;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  next_bit_cnt = 4'h0;
                  if (rw && phase == PH_ADDR) begin
                     next_state = ST_TX;
                     next_shreg = rd_word[7:0];
                     next_hold = rd_word[15:8];
                     next_tx_hi = 1'b1;
                     next_sda_oe = ~rd_word[7];
                  end else begin
                     next_state = ST_RX;
                     next_sda_oe = 1'b0;
                     case (phase)
                        PH_ADDR: next_phase = PH_CMD;
                        PH_CMD: next_phase = PH_LO;
                        PH_LO: next_phase = PH_HI;
                        default: next_phase = PH_LO;
                     endcase
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == LAST_BIT) begin
                     next_state = ST_TXACK;
                     next_sda_oe = 1'b0;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_sda_oe = ~shreg[6];
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise) begin
                  next_nack = sda_sync;
               end else if (scl_fall) begin
                  // A full word has gone out once the high byte is acknowledged or not.
                  next_status_clr = ~tx_hi && cmd == CMD_STATUS;
                  next_bit_cnt = 4'h0;
                  if (nack) begin
                     next_state = ST_IDLE;
                  end else begin
                     next_state = ST_TX;
                     next_shreg = tx_hi ? hold : rd_word[7:0];
                     next_hold = tx_hi ? hold : rd_word[15:8];
                     next_sda_oe = tx_hi ? ~hold[7] : ~rd_word[7];
                     next_tx_hi = ~tx_hi;
                  end
               end
            end
            default: next_state = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state <= ST_IDLE;
         phase <= PH_ADDR;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         cmd <= 8'h00;
         hold <= 8'h00;
         rw <= 1'b0;
         tx_hi <= 1'b0;
         nack <= 1'b0;
         sda_oe <= 1'b0;
         status_clr <= 1'b0;
         measure_config <= CONFIG_RESET;
         upper_limit <= WORD_ZERO;
         lower_limit <= WORD_ZERO;
         power_save_ctrl <= WORD_ZERO;
      end else begin
         state <= next_state;
         phase <= next_phase;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         cmd <= next_cmd;
         hold <= next_hold;
         rw <= next_rw;
         tx_hi <= next_tx_hi;
         nack <= next_nack;
         sda_oe <= next_sda_oe;
         status_clr <= next_status_clr;
         measure_config <= next_measure_config;
         upper_limit <= next_upper_limit;
         lower_limit <= next_lower_limit;
         power_save_ctrl <= next_power_save_ctrl;
      end
   end

   // ----------------------------------------
   // Measurement timing, results and flags
   // ----------------------------------------
   logic        shutdown, irq_en, tick_end, set_up, set_low;
   logic [15:0] tick_cnt, next_tick_cnt;
   logic [12:0] ms_cnt, next_ms_cnt, period_ms;
   logic [3:0]  up_cnt, next_up_cnt, low_cnt, next_low_cnt, pers_target;
   logic [15:0] next_light_result, next_broadband_result;
   logic        next_upper_flag, next_lower_flag, next_meas_start;
   assign shutdown = measure_config[SD_BIT];
   assign irq_en = measure_config[IRQ_BIT];
   assign pers_target = 4'h1 << measure_config[PERS_HI:PERS_LO];
   assign tick_end = tick_cnt == 16'(MS_CYCLES - 1);
   assign limit_crossing_status = {lower_crossing_flag, upper_crossing_flag, 14'h0000};

   always_comb begin
      case (measure_config[IT_HI:IT_LO])
         IT_25: period_ms = MS_25;
         IT_50: period_ms = MS_50;
         IT_200: period_ms = MS_200;
         IT_400: period_ms = MS_400;
         IT_800: period_ms = MS_800;
         default: period_ms = MS_100;
      endcase
      if (power_save_ctrl[PSEN_BIT]) begin
         period_ms = period_ms + (PSM_EXTRA_MS << power_save_ctrl[PSEL_HI:PSEL_LO]);
      end
   end

   always_comb begin
      next_tick_cnt = (shutdown || tick_end) ? 16'h0000 : tick_cnt + 16'h0001;
      next_ms_cnt = ms_cnt;
      next_meas_start = 1'b0;
      if (shutdown) begin
         next_ms_cnt = 13'h0000;
      end else if (tick_end) begin
         if (ms_cnt >= period_ms - 13'h0001) begin
            next_ms_cnt = 13'h0000;
            next_meas_start = 1'b1;
         end else begin
            next_ms_cnt = ms_cnt + 13'h0001;
         end
      end
      next_light_result = light_result;
      next_broadband_result = broadband_result;
      next_up_cnt = up_cnt;
      next_low_cnt = low_cnt;
      set_up = 1'b0;
      set_low = 1'b0;
      if (sample_valid_i && !shutdown) begin
         next_light_result = light_sample_i;
         next_broadband_result = broad_sample_i;
         if (irq_en) begin
            next_up_cnt = light_sample_i > upper_limit ? up_cnt + {3'h0, up_cnt < pers_target} : 4'h0;
            next_low_cnt = light_sample_i < lower_limit ? low_cnt + {3'h0, low_cnt < pers_target} : 4'h0;
            set_up = next_up_cnt >= pers_target;
            set_low = next_low_cnt >= pers_target;
         end
      end
      // A crossing that lands on the clearing read survives it.
      next_upper_flag = set_up | (upper_crossing_flag & ~status_clr);
      next_lower_flag = set_low | (lower_crossing_flag & ~status_clr);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         tick_cnt <= 16'h0000;
         ms_cnt <= 13'h0000;
         meas_start_o <= 1'b0;
         light_result <= WORD_ZERO;
         broadband_result <= WORD_ZERO;
         up_cnt <= 4'h0;
         low_cnt <= 4'h0;
         upper_crossing_flag <= 1'b0;
         lower_crossing_flag <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         shutdown_o <= 1'b1;
         gain_select_o <= 2'h0;
         integration_time_select_o <= 4'h0;
      end else begin
         tick_cnt <= next_tick_cnt;
         ms_cnt <= next_ms_cnt;
         meas_start_o <= next_meas_start;
         light_result <= next_light_result;
         broadband_result <= next_broadband_result;
         up_cnt <= next_up_cnt;
         low_cnt <= next_low_cnt;
         upper_crossing_flag <= next_upper_flag;
         lower_crossing_flag <= next_lower_flag;
         sda_o <= 1'b0;
         sda_oe_o <= next_sda_oe;
         shutdown_o <= next_measure_config[SD_BIT];
         gain_select_o <= next_measure_config[GAIN_HI:GAIN_LO];
         integration_time_select_o <= next_measure_config[IT_HI:IT_LO];
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_byte_end;
      state == ST_RX && scl_fall && bit_cnt == BYTE_BITS && !start_seen && !stop_seen;
   endsequence
   sequence s_read_load;
      state == ST_ACK && scl_fall && rw && phase == PH_ADDR && !start_seen && !stop_seen;
   endsequence

   property p_foreign_addr;
      s_byte_end and (phase == PH_ADDR && shreg[7:1] != TARGET_ADDR) |=> state == ST_IDLE ##1 !sda_oe_o;
   endproperty
   a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acknowledged");
   property p_dir_bit;
      s_byte_end and (phase == PH_ADDR && shreg[7:1] == TARGET_ADDR) |=> rw == $past(shreg[0]) ##1 sda_oe_o;
   endproperty
   a_dir_bit: assert property (p_dir_bit) else $error("direction bit not taken");
   property p_upper_write;
      s_byte_end and (phase == PH_HI && cmd == CMD_UPPER) |=> upper_limit == {$past(shreg), $past(hold)};
   endproperty
   a_upper_write: assert property (p_upper_write) else $error("upper threshold write lost");
   property p_lsb_first;
      s_read_load |=> state == ST_TX && shreg == $past(rd_word[7:0]) && hold == $past(rd_word[15:8]);
   endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("read word not low byte first");
   property p_cfg_reset;
      @(posedge clk_i) disable iff (1'b0) !rst_b_i |=> measure_config == CONFIG_RESET && shutdown_o;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("configuration reset value wrong");
   property p_hold_result;
      shutdown |=> $stable(light_result) && $stable(broadband_result);
   endproperty
   a_hold_result: assert property (p_hold_result) else $error("result changed in shutdown");
   property p_refresh;
      !shutdown && sample_valid_i |=> light_result == $past(light_sample_i);
   endproperty
   a_refresh: assert property (p_refresh) else $error("result not refreshed");
   property p_no_start_sd;
      shutdown [*2] |=> !meas_start_o;
   endproperty
   a_no_start_sd: assert property (p_no_start_sd) else $error("measurement started in shutdown");
   property p_flag_cause;
      $rose(upper_crossing_flag) |-> $past(irq_en && sample_valid_i && light_sample_i > upper_limit);
   endproperty
   a_flag_cause: assert property (p_flag_cause) else $error("upper flag without crossing");
   property p_irq_off;
      !irq_en |=> !$rose(lower_crossing_flag);
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("flag set while evaluation disabled");
endmodule

//--- sim/lsr_host.sv
// Two-wire bus host model that drives the serial clock and data toward the target.
`timescale 1ns/100ps
module lsr_host #(
   // Quarter of the serial clock period, so one bus bit takes 200 ns.
   parameter int Q = 50
) (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Both lines rest released high between frames; the clock stands still there.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic start;
      begin
         @(posedge clk_i);
         #1;
         sda_o = 1'b1;
         #Q scl_o = 1'b1;
         #(2*Q) sda_o = 1'b0;
         #Q scl_o = 1'b0;
         #Q;
      end
   endtask

   task automatic stop;
      begin
         sda_o = 1'b0;
         #Q scl_o = 1'b1;
         #(2*Q) sda_o = 1'b1;
         #(2*Q);
      end
   endtask

   // Data moves mid-way through the low phase, well clear of both clock edges.
   task automatic xfer(input logic [7:0] b, input logic ack_drv, output logic [7:0] rx, output logic ack);
      logic [8:0] t;
      begin
         t = {b, ack_drv};
         for (int i = 8; i >= 0; i--) begin
            sda_o = t[i];
            #Q scl_o = 1'b1;
            #Q t[i] = sda_i;
            #Q scl_o = 1'b0;
            #Q;
         end
         rx  = t[8:1];
         ack = t[0];
      end
   endtask

   task automatic probe(input logic [7:0] a, output logic ack);
      logic [7:0] r;
      begin
         start;
         xfer(a, 1'b1, r, ack);
         stop;
      end
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [15:0] d, output logic ok);
      logic [7:0] r;
      logic [3:0] a;
      begin
         start;
         xfer(8'h20, 1'b1, r, a[0]);
         xfer(cmd, 1'b1, r, a[1]);
         xfer(d[7:0], 1'b1, r, a[2]);
         xfer(d[15:8], 1'b1, r, a[3]);
         stop;
         ok = (a === 4'h0);
      end
   endtask

   task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic ok);
      logic [7:0] r;
      logic [2:0] a;
      logic       n;
      begin
         start;
         xfer(8'h20, 1'b1, r, a[0]);
         xfer(cmd, 1'b1, r, a[1]);
         start;
         xfer(8'h21, 1'b1, r, a[2]);
         xfer(8'hFF, 1'b0, d[7:0], n);
         xfer(8'hFF, 1'b1, d[15:8], n);
         stop;
         ok = (a === 3'h0);
      end
   endtask
endmodule

//--- sim/lsr_regs_tb.sv
// Self-checking testbench for the light sensor command-register block.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_fail++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module lsr_regs_tb;
   import lsr_pkg::*;
   localparam int MS = 2;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [15:0] light = 16'h0000;
   logic [15:0] broad = 16'h0000;
   logic        valid = 1'b0;
   logic        ack;
   wire         host_scl;
   wire         host_sda;
   wire         dev_sda;
   wire         sda_oe;
   wire         sda_w;
   wire         meas_start;
   wire         shutdown;
   wire  [1:0]  gain;
   wire  [3:0]  itime;
   int          n_fail = 0;
   int          n_checks = 0;
   int          n_start = 0;
   int          c;
   logic [3:0]  it_code [6] = '{4'hC, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3};
   int          it_ms [6] = '{25, 50, 100, 200, 400, 800};

   // The data line is pulled up and low whenever either party pulls it.
   assign sda_w = (sda_oe ? dev_sda : 1'b1) & host_sda;

   always #12.5 clk = ~clk;

   // Counted on the falling edge, where the one-cycle pulse stands settled.
   always @(negedge clk) begin
      if (meas_start === 1'b1) begin
         n_start++;
      end
   end

   lsr_regs #(.MS_CYCLES(MS)) dut (
      .clk_i                     (clk),
      .rst_b_i                   (rst_b),
      .scl_i                     (host_scl),
      .sda_i                     (sda_w),
      .sda_o                     (dev_sda),
      .sda_oe_o                  (sda_oe),
      .light_sample_i            (light),
      .broad_sample_i            (broad),
      .sample_valid_i            (valid),
      .meas_start_o              (meas_start),
      .shutdown_o                (shutdown),
      .gain_select_o             (gain),
      .integration_time_select_o (itime)
   );

   lsr_host host (
      .clk_i (clk),
      .sda_i (sda_w),
      .scl_o (host_scl),
      .sda_o (host_sda)
   );

   task automatic close_out;
      begin
         if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
      logic ok;
      begin
         host.wr(cmd, d, ok);
         `CHK("write ack", 1'b1, ok)
      end
   endtask

   task automatic rdc(input logic [7:0] cmd, input logic [15:0] ex);
      logic        ok;
      logic [15:0] d;
      begin
         host.rd(cmd, d, ok);
         `CHK("read ack", 1'b1, ok)
         `CHK("read word", ex, d)
      end
   endtask

   // Front end hands over one conversion; the broadband word is the inverse.
   task automatic smp(input logic [15:0] l);
      begin
         @(posedge clk);
         #1 light = l;
         broad = ~l;
         valid = 1'b1;
         @(posedge clk);
         #1 valid = 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask

   task automatic next_start;
      begin
         c = 0;
         do begin
            @(posedge clk);
            #2;
            c++;
         end while (meas_start !== 1'b1 && c < 20000);
      end
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      close_out;
   end

   initial begin
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) @(posedge clk);
      #2;
      `CHK("shutdown", 1'b1, shutdown)
      `CHK("gain", 2'b00, gain)
      `CHK("itime", 4'h0, itime)
      host.probe(8'h22, ack);
      `CHK("foreign ack", 1'b1, ack)
      host.probe(8'h20, ack);
      `CHK("own ack", 1'b0, ack)
      rdc(8'h07, 16'h0000);
      `CHK("starts", 0, n_start)
      for (int i = 0; i < 6; i++) begin
         wr(CMD_CONFIG, {3'b000, 2'(i), 1'b0, it_code[i], 6'h00});
         `CHK("gain", 2'(i), gain)
         `CHK("itime", it_code[i], itime)
         `CHK("shutdown", 1'b0, shutdown)
         next_start;
         next_start;
         next_start;
         `CHK("period", it_ms[i] * MS, c)
      end
      wr(CMD_CONFIG, 16'h0300);
      wr(CMD_PSAVE, 16'h0003);
      next_start;
      next_start;
      next_start;
      `CHK("saving period", (25 + 1000) * MS, c)
      wr(CMD_PSAVE, 16'h0000);
      smp(16'hA55A);
      rdc(CMD_LIGHT, 16'hA55A);
      rdc(CMD_BROAD, 16'h5AA5);
      wr(CMD_LIGHT, 16'hFFFF);
      rdc(CMD_LIGHT, 16'hA55A);
      wr(CMD_CONFIG, 16'h0301);
      `CHK("shutdown", 1'b1, shutdown)
      smp(16'h1234);
      rdc(CMD_LIGHT, 16'hA55A);
      wr(CMD_CONFIG, 16'h0300);
      smp(16'h1234);
      rdc(CMD_LIGHT, 16'h1234);
      wr(CMD_UPPER, 16'h8000);
      wr(CMD_LOWER, 16'h0100);
      wr(CMD_CONFIG, 16'h0332);
      repeat (7) smp(16'h9000);
      smp(16'h8000);
      repeat (7) smp(16'h9000);
      rdc(CMD_STATUS, 16'h0000);
      smp(16'h9000);
      rdc(CMD_STATUS, 16'h4000);
      wr(CMD_CONFIG, 16'h0302);
      smp(16'h0050);
      rdc(CMD_STATUS, 16'h8000);
      wr(CMD_CONFIG, 16'h0300);
      smp(16'h0050);
      rdc(CMD_STATUS, 16'h0000);
      close_out;
   end
endmodule
